// [hw/hmc_defs.svh]
// offsets, field positions, reset values and timing counts of the halt mode control
`ifndef HMC_DEFS_SVH
`define HMC_DEFS_SVH
`define HMC_ADDR_W            8
`define HMC_DATA_W            32
`define HMC_ADDR_HALT_CTRL    8'h38
`define HMC_ADDR_RUN_CTRL     8'h3c
`define HMC_ADDR_STATUS       8'h40
`define HMC_HALT_START_BIT    7
`define HMC_RELEASE_BIT       6
`define HMC_POST_WAKE_BIT     5
`define HMC_PORT_HOLD_BIT     4
`define HMC_WARM_MSB          3
`define HMC_WARM_LSB          2
`define HMC_HALT_CTRL_RST     8'h00
`define HMC_RUN_FAST_EN_BIT   0
`define HMC_RUN_SLOW_EN_BIT   1
`define HMC_RUN_SLOW_SEL_BIT  2
`define HMC_RUN_CTRL_RST      3'h1
`define HMC_ST_HALTED_BIT     4
`define HMC_ST_WARMING_BIT    5
`define HMC_ST_WAKE_PIN_BIT   6
`define HMC_FC_HZ             20000000
`define HMC_FS_HZ             32768
`define HMC_SLOW_DIV          (`HMC_FC_HZ / `HMC_FS_HZ)
`define HMC_MCYC_STATES       4
`define HMC_WARM_W            18
`define HMC_WARM_F0           (3 * (2 ** 16))
`define HMC_WARM_F1           (2 ** 16)
`define HMC_WARM_F2           (3 * (2 ** 14))
`define HMC_WARM_F3           (2 ** 14)
`define HMC_WARM_S0           (3 * (2 ** 13))
`define HMC_WARM_S1           (2 ** 13)
`define HMC_WARM_S2           (3 * (2 ** 6))
`define HMC_WARM_S3           (2 ** 6)
`endif

// [hw/hmc_pkg.sv]
// types of the halt mode control
`include "hmc_defs.svh"
package hmc_pkg;
  typedef enum logic [1:0] {
    fast_run_single_osc,
    fast_run_dual_osc,
    slow_run_both_osc,
    slow_run_fast_osc_off
  } hmc_run_mode_t;
  typedef enum {st_run, st_halt, st_warm} hmc_state_t;
  typedef logic [`HMC_WARM_W-1:0] hmc_warm_cnt_t;
endpackage

// [hw/hmc_tim_if.sv]
// ticks and warm-up handshake between the controller and its timers
`timescale 1ns/1ps
`default_nettype none
`include "hmc_defs.svh"
interface hmc_tim_if;
  logic                     slow_osc_on;
  logic                     div_clr;
  logic                     main_slow;
  logic                     slow_tick;
  logic                     mcyc_en;
  logic                     warm_start;
  logic                     warm_slow;
  logic [`HMC_WARM_W-1:0]   warm_load;
  logic                     warm_done;
  modport div  (input slow_osc_on, div_clr, main_slow, output slow_tick, mcyc_en);
  modport warm (input slow_tick, warm_start, warm_slow, warm_load, output warm_done);
  modport ctl  (output slow_osc_on, div_clr, main_slow, warm_start, warm_slow, warm_load,
                input slow_tick, mcyc_en, warm_done);
endinterface
`default_nettype wire

// [hw/hmc_clk_div.sv]
// slow clock tick prescaler and machine cycle divider
`timescale 1ns/1ps
`default_nettype none
`include "hmc_defs.svh"
module hmc_clk_div #(
  parameter int unsigned SLOW_DIV = `HMC_SLOW_DIV,
  parameter int unsigned MCYC     = `HMC_MCYC_STATES
) (
  input  wire logic  sys_clk_i,
  input  wire logic  nrst_i,
  hmc_tim_if.div     tim
);
  localparam int PW = $clog2(SLOW_DIV);
  localparam int MW = $clog2(MCYC);
  logic [PW-1:0] pre_q;
  logic [MW-1:0] mc_q;
  wire           pre_end = pre_q == PW'(SLOW_DIV - 1);
  wire           base    = tim.main_slow ? tim.slow_tick : 1'b1;
  wire           mc_end  = mc_q == MW'(MCYC - 1);
  // stopped oscillator gives no ticks and restarts from zero
  assign tim.slow_tick = tim.slow_osc_on & pre_end;
  assign tim.mcyc_en   = ~tim.div_clr & base & mc_end;
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || !tim.slow_osc_on || pre_end) pre_q <= '0;
    else pre_q <= pre_q + 1'b1;
  end
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || tim.div_clr) mc_q <= '0;
    else if (base) mc_q <= mc_end ? '0 : mc_q + 1'b1;
  end
endmodule
`default_nettype wire

// [hw/hmc_warmup_timer.sv]
// warm-up down counter, counting fast clocks or slow ticks
`timescale 1ns/1ps
`default_nettype none
`include "hmc_defs.svh"
module hmc_warmup_timer (
  input  wire logic  sys_clk_i,
  input  wire logic  nrst_i,
  hmc_tim_if.warm    tim
);
  import hmc_pkg::*;
  hmc_warm_cnt_t cnt_q;
  logic          busy_q;
  logic          done_q;
  wire           tick = tim.warm_slow ? tim.slow_tick : 1'b1;
  wire           last = busy_q & tick & (cnt_q == hmc_warm_cnt_t'(1));
  assign tim.warm_done = done_q;
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (tim.warm_start) begin
      cnt_q  <= tim.warm_load;
      busy_q <= 1'b1;
    end else if (busy_q && tick) begin
      cnt_q  <= cnt_q - 1'b1;
      busy_q <= ~last;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) done_q <= 1'b0;
    else done_q <= last;
  end
endmodule
`default_nettype wire

// [hw/hmc_top.sv]
// run mode and deep halt control with its apb register file
// Overview of operation
// [R1] bit 7 of the halt control register set halts core and peripherals
// [R2] bit 6 picks wake method: 0 wake pin edge, 1 wake pin level
// [R3] bit 5 picks post-wake mode: 0 fast run, 1 slow run fast osc off
// [R4] bit 4 during halt: 0 ports high impedance, 1 ports keep levels
// [R5] two warm-up bits pick one of four fast or four slow delays
// [R6] software sets bit 5 to match the run mode it halts from
// [R7] reset during halt always returns to single-oscillator fast run
// [R8] the two lowest bits of the halt control register read undefined
// [R9] reset clears bits 7 to 2 of the halt control register
// [R10] halt without hold forces pin input values to zero
// [R11] the wake pin goes high impedance whenever halt starts
// [R12] software picks level release when key wake-up inputs are used
// [R13] machine cycle is four fast or four slow clocks, none in halt
// [R14] halt stops oscillators, keeps state, clears prescaler and divider
// [R15] level release wakes on high pin, edge release on rising edge
// [R16] wake restarts oscillators, holds everything for warm-up, then resumes
// [R17] after reset the block runs single-oscillator fast run
// [R18] the halt start bit reads zero once execution has resumed
`timescale 1ns/1ps
`default_nettype none
`include "hmc_defs.svh"
module hmc_top #(
  parameter int unsigned SLOW_DIV = `HMC_SLOW_DIV,
  parameter int unsigned WARM_F0  = `HMC_WARM_F0,
  parameter int unsigned WARM_F1  = `HMC_WARM_F1,
  parameter int unsigned WARM_F2  = `HMC_WARM_F2,
  parameter int unsigned WARM_F3  = `HMC_WARM_F3,
  parameter int unsigned WARM_S0  = `HMC_WARM_S0,
  parameter int unsigned WARM_S1  = `HMC_WARM_S1,
  parameter int unsigned WARM_S2  = `HMC_WARM_S2,
  parameter int unsigned WARM_S3  = `HMC_WARM_S3
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [`HMC_ADDR_W-1:0]  paddr_i,
  input  wire logic [`HMC_DATA_W-1:0]  pwdata_i,
  output logic      [`HMC_DATA_W-1:0]  prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  input  wire logic                    wake_pin_i,
  output hmc_pkg::hmc_run_mode_t       run_mode_o,
  output logic                         cpu_clk_en_o,
  output logic                         periph_clk_en_o,
  output logic                         tbt_clk_en_o,
  output logic                         mcyc_en_o,
  output logic                         fast_osc_on_o,
  output logic                         slow_osc_on_o,
  output logic                         main_clk_slow_o,
  output logic                         div_clr_o,
  output logic                         halted_o,
  output logic                         warming_o,
  output logic                         port_out_hiz_o,
  output logic                         port_in_zero_o,
  output logic                         wake_pin_hiz_o
);
  import hmc_pkg::*;

  localparam hmc_warm_cnt_t WARM_FAST [4] = '{
    hmc_warm_cnt_t'(WARM_F0), hmc_warm_cnt_t'(WARM_F1),
    hmc_warm_cnt_t'(WARM_F2), hmc_warm_cnt_t'(WARM_F3)
  };
  localparam hmc_warm_cnt_t WARM_SLOW [4] = '{
    hmc_warm_cnt_t'(WARM_S0), hmc_warm_cnt_t'(WARM_S1),
    hmc_warm_cnt_t'(WARM_S2), hmc_warm_cnt_t'(WARM_S3)
  };

  function automatic logic addr_is(
    input logic [`HMC_ADDR_W-1:0] addr,
    input logic [`HMC_ADDR_W-1:0] base
  );
    return addr == base;
  endfunction

  // a run control word is refused when the selected clock has no oscillator
  function automatic logic run_ctrl_ok(input logic [2:0] rc);
    logic need;
    need = rc[`HMC_RUN_SLOW_SEL_BIT] ? rc[`HMC_RUN_SLOW_EN_BIT]
                                     : rc[`HMC_RUN_FAST_EN_BIT];
    return need;
  endfunction

  function automatic hmc_run_mode_t run_mode_of(input logic [2:0] rc);
    hmc_run_mode_t m;
    if (rc[`HMC_RUN_SLOW_SEL_BIT])
      m = rc[`HMC_RUN_FAST_EN_BIT] ? slow_run_both_osc : slow_run_fast_osc_off;
    else
      m = rc[`HMC_RUN_SLOW_EN_BIT] ? fast_run_dual_osc : fast_run_single_osc;
    return m;
  endfunction

  function automatic hmc_warm_cnt_t warm_count(
    input logic       slow,
    input logic [1:0] code
  );
    return slow ? WARM_SLOW[code] : WARM_FAST[code];
  endfunction

  hmc_state_t               st_q;
  hmc_state_t               st_d;
  logic [7:0]               hc_q;
  logic [7:0]               hc_d;
  logic [2:0]               rc_q;
  logic [2:0]               rc_d;
  logic                     wake_prev_q;
  logic [`HMC_DATA_W-1:0]   prdata_q;
  logic [`HMC_DATA_W-1:0]   rdata_d;
  logic [7:0]               status_w;

  hmc_tim_if tim ();

  hmc_clk_div #(
    .SLOW_DIV (SLOW_DIV),
    .MCYC     (`HMC_MCYC_STATES)
  ) u_div (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .tim       (tim.div)
  );

  hmc_warmup_timer u_warm (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .tim       (tim.warm)
  );

  // bus decode
  wire in_run    = st_q == st_run;
  wire in_halt   = st_q == st_halt;
  wire in_warm   = st_q == st_warm;
  wire stopped   = ~in_run;
  wire setup     = psel_i & ~penable_i;
  wire access    = psel_i & penable_i;
  wire sel_halt  = addr_is(paddr_i, `HMC_ADDR_HALT_CTRL);
  wire sel_run   = addr_is(paddr_i, `HMC_ADDR_RUN_CTRL);
  wire sel_stat  = addr_is(paddr_i, `HMC_ADDR_STATUS);
  wire unmapped  = ~(sel_halt | sel_run | sel_stat);
  wire rc_ok     = run_ctrl_ok(pwdata_i[2:0]);
  // registers are frozen while the core is halted or warming up
  wire wr_ok     = access & pwrite_i & in_run;
  wire wr_halt   = wr_ok & sel_halt;
  wire wr_run    = wr_ok & sel_run & rc_ok;
  wire wr_bad    = pwrite_i & (sel_stat | stopped | (sel_run & ~rc_ok));

  assign pready_o  = 1'b1;
  assign pslverr_o = access & (unmapped | wr_bad);
  assign prdata_o  = prdata_q;

  // halt start and the configuration it uses
  wire       halt_go   = wr_halt & pwdata_i[`HMC_HALT_START_BIT]; // [R1]
  wire [7:0] cfg       = halt_go ? pwdata_i[7:0] : hc_q;
  wire       cfg_level = cfg[`HMC_RELEASE_BIT];
  wire       cfg_slow  = cfg[`HMC_POST_WAKE_BIT];
  wire       cfg_hold  = cfg[`HMC_PORT_HOLD_BIT];
  wire [1:0] cfg_wut   = cfg[`HMC_WARM_MSB:`HMC_WARM_LSB];

  // wake detection; pin is synchronous so one stage suffices for the edge
  wire pin_rise  = wake_pin_i & ~wake_prev_q;
  wire wake_lvl  = cfg_level & wake_pin_i; // [R15]
  wire wake_edge = ~cfg_level & pin_rise; // [R15]
  wire wake_now  = in_halt & (wake_lvl | wake_edge); // [R2]
  // level mode with the pin already high skips straight to warm-up
  wire go_warm   = halt_go & cfg_level & wake_pin_i;
  wire warm_go   = wake_now | go_warm;
  wire resumed   = in_warm & tim.warm_done;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      st_run: begin
        if (halt_go) st_d = go_warm ? st_warm : st_halt; // [R1]
      end
      st_halt: begin
        if (wake_now) st_d = st_warm; // [R16]
      end
      st_warm: begin
        if (tim.warm_done) st_d = st_run; // [R16]
      end
    endcase
  end

  always_comb begin
    hc_d = hc_q;
    if (wr_halt)
      hc_d = {pwdata_i[7:2], 2'b00};
    if (resumed)
      hc_d[`HMC_HALT_START_BIT] = 1'b0; // [R18]
  end

  // post-wake mode overrides the run control word
  always_comb begin
    rc_d = rc_q;
    if (wr_run)
      rc_d = pwdata_i[2:0];
    if (resumed) begin
      if (cfg_slow) begin
        rc_d[`HMC_RUN_SLOW_SEL_BIT] = 1'b1; // [R3]
        rc_d[`HMC_RUN_SLOW_EN_BIT]  = 1'b1;
        rc_d[`HMC_RUN_FAST_EN_BIT]  = 1'b0;
      end else begin
        rc_d[`HMC_RUN_SLOW_SEL_BIT] = 1'b0; // [R3]
        rc_d[`HMC_RUN_FAST_EN_BIT]  = 1'b1;
      end
    end
  end

  // reset ends any halt in single-oscillator fast run
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      st_q <= st_run; // [R7] [R17]
      hc_q <= `HMC_HALT_CTRL_RST; // [R9]
      rc_q <= `HMC_RUN_CTRL_RST; // [R17]
    end else begin
      st_q <= st_d;
      hc_q <= hc_d;
      rc_q <= rc_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) wake_prev_q <= 1'b0;
    else wake_prev_q <= wake_pin_i;
  end

  // read data
  always_comb begin
    status_w = '0;
    status_w[1:0] = run_mode_of(rc_q);
    status_w[`HMC_ST_HALTED_BIT] = in_halt;
    status_w[`HMC_ST_WARMING_BIT] = in_warm;
    status_w[`HMC_ST_WAKE_PIN_BIT] = wake_pin_i;
  end

  // the two low bits have no defined content and simply read zero
  always_comb begin
    rdata_d = '0;
    if (sel_halt)
      rdata_d[7:0] = {hc_q[7:2], 2'b00}; // [R8]
    else if (sel_run)
      rdata_d[2:0] = rc_q;
    else if (sel_stat)
      rdata_d[7:0] = status_w;
  end

  // captured in setup so the access phase needs no wait state
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) prdata_q <= '0;
    else if (setup) prdata_q <= rdata_d;
  end

  // timers
  assign tim.warm_start  = warm_go; // [R16]
  assign tim.warm_slow   = cfg_slow;
  assign tim.warm_load   = warm_count(cfg_slow, cfg_wut); // [R5]
  // divider stays cleared from halt until execution resumes; prescaler only while the slow oscillator is off
  assign tim.div_clr     = stopped; // [R14]
  assign tim.main_slow   = in_run ? rc_q[`HMC_RUN_SLOW_SEL_BIT] : cfg_slow; // [R13]

  // oscillators: all off in halt, only the needed ones during warm-up
  assign fast_osc_on_o   = in_run ? rc_q[`HMC_RUN_FAST_EN_BIT]
                                  : in_warm & ~cfg_slow; // [R14] [R16]
  assign slow_osc_on_o   = in_run ? rc_q[`HMC_RUN_SLOW_EN_BIT]
                                  : in_warm & (cfg_slow | rc_q[`HMC_RUN_SLOW_EN_BIT]); // [R16]
  assign tim.slow_osc_on = slow_osc_on_o;

  // core, time base timer and peripherals all halt outside run
  assign cpu_clk_en_o    = in_run; // [R1]
  assign periph_clk_en_o = in_run; // [R1]
  assign tbt_clk_en_o    = in_run; // [R13]
  assign mcyc_en_o       = tim.mcyc_en; // [R13]
  assign main_clk_slow_o = tim.main_slow;
  assign div_clr_o       = tim.div_clr;
  assign run_mode_o      = run_mode_of(rc_q);
  assign halted_o        = in_halt;
  assign warming_o       = in_warm;

  // port behaviour spans the whole stop period including warm-up
  assign port_out_hiz_o  = stopped & ~cfg_hold; // [R4]
  // forced zero may look like a falling edge to external interrupts
  assign port_in_zero_o  = stopped & ~cfg_hold; // [R10]
  assign wake_pin_hiz_o  = stopped; // [R11]

endmodule
`default_nettype wire

// [sim/hmc_top_properties.sv]
// port assertions and covers for the halt mode control
`include "hmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module hmc_top_checker (
  input wire logic                   sys_clk_i,
  input wire logic                   nrst_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [`HMC_ADDR_W-1:0] paddr_i,
  input wire logic [`HMC_DATA_W-1:0] pwdata_i,
  input wire logic                   wake_pin_i,
  input wire hmc_pkg::hmc_run_mode_t run_mode_o,
  input wire logic                   cpu_clk_en_o,
  input wire logic                   mcyc_en_o,
  input wire logic                   fast_osc_on_o,
  input wire logic                   main_clk_slow_o,
  input wire logic                   halted_o,
  input wire logic                   warming_o,
  input wire logic                   port_out_hiz_o,
  input wire logic                   port_in_zero_o,
  input wire logic                   wake_pin_hiz_o
);
  import hmc_pkg::*;
  logic rel_q;
  logic hold_q;
  logic busy;
  logic hc_wr;
  assign busy = halted_o || warming_o;
  assign hc_wr = psel_i && penable_i && pwrite_i && paddr_i == `HMC_ADDR_HALT_CTRL && !busy;
  // mirror only accepted writes, the block refuses them in halt
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rel_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (hc_wr) begin
      rel_q <= pwdata_i[6];
      hold_q <= pwdata_i[4];
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_HALT_ENTRY: assert property (
    hc_wr && pwdata_i[7] && !wake_pin_i |=> halted_o && !cpu_clk_en_o)
    else $error("halt not entered");
  AST_LEVEL_AT_ENTRY: assert property (
    hc_wr && pwdata_i[7] && pwdata_i[6] && wake_pin_i |=> warming_o)
    else $error("level start with pin high did not warm up");
  AST_STOPPED: assert property (busy |-> !cpu_clk_en_o && !mcyc_en_o)
    else $error("core clocked in halt");
  AST_OSC_OFF: assert property (halted_o |-> !fast_osc_on_o)
    else $error("fast oscillator on in halt");
  AST_LEVEL_WAKE: assert property (halted_o && rel_q && wake_pin_i |=> warming_o)
    else $error("no level wake");
  AST_EDGE_WAKE: assert property (halted_o && !rel_q && $rose(wake_pin_i) |=> warming_o)
    else $error("no edge wake");
  AST_EDGE_HOLD: assert property (
    halted_o && !rel_q && !$rose(wake_pin_i) |=> halted_o)
    else $error("edge halt left without rising edge");
  AST_PORTS: assert property (
    busy |-> wake_pin_hiz_o && port_out_hiz_o == !hold_q && port_in_zero_o == !hold_q)
    else $error("port state wrong in halt");
  AST_RESET_MODE: assert property (
    $rose(nrst_i) |-> run_mode_o == fast_run_single_osc && cpu_clk_en_o && !busy)
    else $error("not fast single run after reset");
  AST_MCYC_GAP: assert property (mcyc_en_o && !main_clk_slow_o |=> !mcyc_en_o [*3])
    else $error("machine cycle shorter than four clocks");
  cover property (halted_o && !rel_q ##1 warming_o);
  cover property (halted_o && rel_q ##1 warming_o);
  cover property ($fell(warming_o) && main_clk_slow_o);
endmodule
bind hmc_top hmc_top_checker u_chk (
  .sys_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .wake_pin_i,
  .run_mode_o, .cpu_clk_en_o, .mcyc_en_o, .fast_osc_on_o, .main_clk_slow_o, .halted_o,
  .warming_o, .port_out_hiz_o, .port_in_zero_o, .wake_pin_hiz_o);
`default_nettype wire

// [sim/hmc_wake_src.sv]
// wake pin source: follows the wanted level after a set delay
`timescale 1ns/1ps
`default_nettype none
module hmc_wake_src (
  input  wire logic       sys_clk_i,
  input  wire logic       want_i,
  input  wire logic [3:0] dly_i,
  output logic            wake_pin_o
);
  logic [3:0] cnt_q = 4'h0;
  initial wake_pin_o = 1'b0;
  // pin is always driven, so the delay alone makes a prompt or slow source
  always @(posedge sys_clk_i) begin
    if (want_i == wake_pin_o || cnt_q >= dly_i) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
    if (want_i != wake_pin_o && cnt_q >= dly_i) begin
      wake_pin_o <= want_i;
    end
  end
endmodule
`default_nettype wire

// [sim/hmc_top_tb_top.sv]
// self-checking bench for the halt mode control
`timescale 1ns/1ps
`default_nettype none
module hmc_top_tb_top;
  import hmc_pkg::*;
  localparam int unsigned SDIV = 4;
  localparam int unsigned WC[4] = '{8, 6, 4, 2};
  logic        sys_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        want = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic [31:0] seed = 32'h3483;
  wire logic [31:0] prdata_o;
  wire logic wake_pin_i, pready_o, pslverr_o, cpu_clk_en_o, periph_clk_en_o, tbt_clk_en_o;
  wire logic mcyc_en_o, fast_osc_on_o, slow_osc_on_o, main_clk_slow_o, div_clr_o, halted_o;
  wire logic warming_o, port_out_hiz_o, port_in_zero_o, wake_pin_hiz_o;
  wire hmc_run_mode_t run_mode_o;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  hmc_top #(.SLOW_DIV(SDIV), .WARM_F0(WC[0]), .WARM_F1(WC[1]), .WARM_F2(WC[2]),
    .WARM_F3(WC[3]), .WARM_S0(WC[0]), .WARM_S1(WC[1]), .WARM_S2(WC[2]),
    .WARM_S3(WC[3])) dut (
    .sys_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .wake_pin_i, .run_mode_o, .cpu_clk_en_o, .periph_clk_en_o,
    .tbt_clk_en_o, .mcyc_en_o, .fast_osc_on_o, .slow_osc_on_o, .main_clk_slow_o,
    .div_clr_o, .halted_o, .warming_o, .port_out_hiz_o, .port_in_zero_o, .wake_pin_hiz_o);
  hmc_wake_src src (.sys_clk_i, .want_i(want), .dly_i(dly), .wake_pin_o(wake_pin_i));
  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // entered just after a rising edge; answer taken from the values standing at the edge
  task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                    input logic [31:0] exp, input logic exp_err);
    logic rdy;
    logic err;
    logic [31:0] rd;
    rdy = 1'b0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // answer taken at the rising edge that completes the access; only the timeout ends a wait
    while (!rdy) begin
      @(posedge sys_clk_i);
      rdy = (pready_o === 1'b1);
      rd = prdata_o;
      err = pslverr_o;
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
    chk("pready", 1, rdy);
    chk("pslverr", exp_err, err);
    if (!wr) chk("prdata", exp, rd);
  endtask
  task automatic wake_up(output int n);
    int k;
    k = 0;
    n = 0;
    want <= 1'b1;
    while (warming_o !== 1'b1 && k < 100) begin
      @(negedge sys_clk_i);
      k++;
    end
    while (cpu_clk_en_o !== 1'b1 && n < 200) begin
      @(negedge sys_clk_i);
      n++;
    end
    @(posedge sys_clk_i);
  endtask
  task automatic halt_run(input logic rel, input logic post, input logic hold,
                          input logic [1:0] code);
    int n;
    int e;
    e = post ? WC[code] * SDIV : WC[code];
    while (wake_pin_i !== 1'b0) @(posedge sys_clk_i);
    rw(1'b1, 8'h38, {24'h0, 1'b1, rel, post, hold, code, 2'b00}, 32'h0, 1'b0);
    @(negedge sys_clk_i);
    chk("halted", 1, halted_o);
    chk("fast_osc", 0, fast_osc_on_o);
    chk("port_hiz", !hold, port_out_hiz_o);
    chk("in_zero", !hold, port_in_zero_o);
    chk("pin_hiz", 1, wake_pin_hiz_o);
    @(posedge sys_clk_i);
    rw(1'b1, 8'h38, 32'h0, 32'h0, 1'b1);
    wake_up(n);
    chk("warm_len", 1, n + 1 >= e && n <= e + SDIV + 2);
    want <= 1'b0;
    rw(1'b0, 8'h38, 32'h0, {24'h0, 1'b0, rel, post, hold, code, 2'b00}, 1'b0);
    chk("mode", post ? 3 : 0, run_mode_o);
  endtask
  initial begin
    int n;
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    rw(1'b0, 8'h38, 32'h0, 32'h0, 1'b0);
    rw(1'b0, 8'h3c, 32'h0, 32'h1, 1'b0);
    n = 0;
    repeat (40) begin
      @(negedge sys_clk_i);
      n += mcyc_en_o;
    end
    chk("mcyc", 10, n);
    @(posedge sys_clk_i);
    rw(1'b0, 8'h44, 32'h0, 32'h0, 1'b1);
    rw(1'b1, 8'h40, 32'hff, 32'h0, 1'b1);
    for (int c = 0; c < 10; c++) begin
      seed = lfsr(seed);
      dly <= seed[3:0];
      rw(1'b1, 8'h38, seed & 32'h7f, 32'h0, 1'b0);
      rw(1'b0, 8'h38, 32'h0, seed & 32'h7c, 1'b0);
      halt_run(seed[8], 1'b0, seed[9], c < 4 ? c[1:0] : seed[11:10]);
    end
    want <= 1'b1;
    while (wake_pin_i !== 1'b1) @(posedge sys_clk_i);
    rw(1'b1, 8'h38, 32'h80, 32'h0, 1'b0);
    want <= 1'b0;
    repeat (20) @(negedge sys_clk_i);
    chk("halted", 1, halted_o);
    @(posedge sys_clk_i);
    wake_up(n);
    rw(1'b1, 8'h38, 32'hc0, 32'h0, 1'b0);
    @(negedge sys_clk_i);
    chk("warming", 1, warming_o);
    wake_up(n);
    want <= 1'b0;
    rw(1'b1, 8'h3c, 32'h3, 32'h0, 1'b0);
    rw(1'b1, 8'h3c, 32'h7, 32'h0, 1'b0);
    chk("mode", 2, run_mode_o);
    for (int c = 0; c < 4; c++) halt_run(c[0], 1'b1, c[1], c[1:0]);
    rw(1'b1, 8'h38, 32'hb0, 32'h0, 1'b0);
    nrst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(negedge sys_clk_i);
    chk("mode", 0, run_mode_o);
    chk("halted", 0, halted_o);
    wrap_up();
  end
endmodule
`default_nettype wire
